// File: inc/swsc_pkg.sv
// Package with register map, field layout and codes of the standby wake-source block
package swsc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] mode_a_offset    = 12'h000;
	localparam logic [11:0] irq_clear_offset = 12'h004;
	localparam logic [11:0] pending_offset   = 12'h008;
	localparam logic [11:0] release_offset   = 12'h00c;

	localparam int num_inputs = 4;

	// ----------------------------------------------------------------
	// Field layout: each input owns one byte lane of the mode register
	// ----------------------------------------------------------------
	localparam int lane_width    = 8;
	localparam int cond_lsb      = 4;
	localparam int edge_seen_lsb = 2;
	localparam int enable_lsb    = 0;

	// ----------------------------------------------------------------
	// Detection conditions and edge status codes
	// ----------------------------------------------------------------
	localparam logic [2:0] cond_low     = 3'h0;
	localparam logic [2:0] cond_high    = 3'h1;
	localparam logic [2:0] cond_falling = 3'h2;
	localparam logic [2:0] cond_rising  = 3'h3;
	localparam logic [2:0] cond_either  = 3'h4;

	localparam logic [1:0] seen_none    = 2'h0;
	localparam logic [1:0] seen_rising  = 2'h1;
	localparam logic [1:0] seen_falling = 2'h2;
	localparam logic [1:0] seen_both    = 2'h3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] cond_reset   = cond_falling;
	localparam logic [1:0] seen_reset   = seen_none;
	localparam logic       enable_reset = 1'b0;

endpackage : swsc_pkg

// File: design/swsc_detect.sv
// One wake input: edge/level detection and edge status
`timescale 1ns/10ps
`default_nettype none
module swsc_detect (
	input  wire logic       clk,        // System clock
	input  wire logic       reset,      // Synchronous reset, active high
	input  wire logic       pin,        // Wake input level
	input  wire logic [2:0] condition,  // Detection condition code
	input  wire logic       enable,     // Input enabled as release source
	input  wire logic       clear,      // Clear edge status
	output logic            hit,        // Release condition met this cycle
	output logic      [1:0] edge_seen   // Edge that released standby in either-edge mode
);
	logic       pin_reg,  pin_next;
	logic [1:0] seen_reg, seen_next;
	logic       rise, fall;

	always_comb begin
		rise      = pin & ~pin_reg;
		fall      = ~pin & pin_reg;
		pin_next  = pin;
		seen_next = seen_reg;
		hit       = 1'b0;
		if (enable) begin
			unique case (condition)
				swsc_pkg::cond_low:     hit = ~pin;
				swsc_pkg::cond_high:    hit = pin;
				swsc_pkg::cond_falling: hit = fall;
				swsc_pkg::cond_rising:  hit = rise;
				swsc_pkg::cond_either:  hit = rise | fall;
				default:                hit = 1'b0;
			endcase
		end
		// Clear first so a coincident edge is still recorded
		if (clear)
			seen_next = swsc_pkg::seen_none;
		if (hit && condition == swsc_pkg::cond_either) begin
			if (rise)
				seen_next = seen_next | swsc_pkg::seen_rising;
			if (fall)
				seen_next = seen_next | swsc_pkg::seen_falling;
		end
		// Pin history keeps following the pin in reset, so a pin high at release gives no false edge
		if (reset) begin
			seen_next = swsc_pkg::seen_reset;
		end
	end

	always_ff @(posedge clk) begin
		pin_reg  <= pin_next;
		seen_reg <= seen_next;
	end

	assign edge_seen = seen_reg;

endmodule : swsc_detect
`default_nettype wire

// File: design/swsc_top.sv
// Standby wake-source configuration and status block with APB slave
`timescale 1ns/10ps
`default_nettype none
module swsc_top (
	input  wire logic        clk,             // System clock, 200 MHz
	input  wire logic        reset,           // Synchronous reset, active high
	input  wire logic        psel,            // APB select
	input  wire logic        penable,         // APB enable
	input  wire logic        pwrite,          // APB write
	input  wire logic [11:0] paddr,           // APB byte address
	input  wire logic [31:0] pwdata,          // APB write data
	output logic      [31:0] prdata,          // APB read data
	output logic             pready,          // APB ready
	output logic             pslverr,         // APB error on unmapped address
	input  wire logic  [3:0] wake_input,      // Wake input pins 0 to 3
	output logic       [3:0] wake_pending,    // Pending wake interrupt per input
	output logic             standby_release  // Release request to standby logic
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [2:0]  cond_reg [4];
	logic [2:0]  cond_next [4];
	logic [3:0]  en_reg, en_next;
	logic [3:0]  pend_reg, pend_next;
	logic [3:0]  rel_src_reg, rel_src_next;
	logic        release_reg, release_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        ready_reg, ready_next;
	logic        err_reg, err_next;
	logic [3:0]  hit;
	logic [3:0]  clr;
	logic [1:0]  seen [4];
	logic        wr_acc, rd_acc, mapped;

	function automatic logic [7:0] lane_pack(input logic [2:0] c, input logic [1:0] s, input logic e);
		lane_pack = '0;
		lane_pack[swsc_pkg::cond_lsb +: 3]      = c;
		lane_pack[swsc_pkg::edge_seen_lsb +: 2] = s;
		lane_pack[swsc_pkg::enable_lsb]         = e;
	endfunction : lane_pack

	// ----------------------------------------------------------------
	// Per-input detectors
	// ----------------------------------------------------------------
	for (genvar i = 0; i < swsc_pkg::num_inputs; i++) begin : g_det
		swsc_detect u_det (
			.clk       (clk),
			.reset     (reset),
			.pin       (wake_input[i]),
			.condition (cond_reg[i]),
			.enable    (en_reg[i]),
			.clear     (clr[i]),
			.hit       (hit[i]),
			.edge_seen (seen[i])
		);
	end

	// ----------------------------------------------------------------
	// APB decode and register update
	// ----------------------------------------------------------------
	// Single wait state: access is taken when pready is seen high
	assign wr_acc = psel & penable & pwrite & ready_reg;
	assign rd_acc = psel & penable & ~pwrite & ready_reg;
	assign mapped = (paddr == swsc_pkg::mode_a_offset) || (paddr == swsc_pkg::irq_clear_offset)
	             || (paddr == swsc_pkg::pending_offset) || (paddr == swsc_pkg::release_offset);
	assign clr    = (wr_acc && paddr == swsc_pkg::irq_clear_offset) ? pwdata[3:0] : 4'h0;

	always_comb begin
		for (int i = 0; i < 4; i++)
			cond_next[i] = cond_reg[i];
		en_next      = en_reg;
		rel_src_next = rel_src_reg;
		ready_next   = psel & penable & ~ready_reg;
		err_next     = psel & penable & ~ready_reg & ~mapped;
		rdata_next   = rdata_reg;
		// Set wins over clear so a wake arriving during the clear is kept
		pend_next    = (pend_reg & ~clr) | hit;
		release_next = |hit;
		if (|hit)
			rel_src_next = hit;
		if (wr_acc && paddr == swsc_pkg::mode_a_offset) begin
			for (int i = 0; i < 4; i++) begin
				// Lane layout gives bits 30-28/27-26/24 down to 6-4/3-2/0
				cond_next[i] = pwdata[i*swsc_pkg::lane_width + swsc_pkg::cond_lsb +: 3];
				en_next[i]   = pwdata[i*swsc_pkg::lane_width + swsc_pkg::enable_lsb];
			end
		end
		if (psel && penable && !pwrite && !ready_reg) begin
			rdata_next = 32'h0;
			unique case (paddr)
				swsc_pkg::mode_a_offset: begin
					for (int i = 0; i < 4; i++)
						rdata_next[i*8 +: 8] = lane_pack(cond_reg[i], seen[i], en_reg[i]);
				end
				swsc_pkg::pending_offset: rdata_next[3:0] = pend_reg;
				swsc_pkg::release_offset: rdata_next[3:0] = rel_src_reg;
				default:                  rdata_next = 32'h0;
			endcase
		end
		if (reset) begin
			for (int i = 0; i < 4; i++)
				cond_next[i] = swsc_pkg::cond_reset;
			en_next      = {4{swsc_pkg::enable_reset}};
			pend_next    = 4'h0;
			rel_src_next = 4'h0;
			release_next = 1'b0;
			rdata_next   = 32'h0;
			ready_next   = 1'b0;
			err_next     = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++)
			cond_reg[i] <= cond_next[i];
		en_reg      <= en_next;
		pend_reg    <= pend_next;
		rel_src_reg <= rel_src_next;
		release_reg <= release_next;
		rdata_reg   <= rdata_next;
		ready_reg   <= ready_next;
		err_reg     <= err_next;
	end

	assign prdata          = rdata_reg;
	assign pready          = ready_reg;
	assign pslverr         = err_reg;
	assign wake_pending    = pend_reg;
	assign standby_release = release_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_reset_cond_value: assert property ($past(reset)
		|-> cond_reg[3] == swsc_pkg::cond_falling && en_reg == 4'h0)
		else $error("condition or enable wrong after reset");
	a_reset_status: assert property ($past(reset)
		|-> seen[2] == swsc_pkg::seen_none && seen[3] == swsc_pkg::seen_none && wake_pending == 4'h0)
		else $error("edge status or pending wrong after reset");
	a_disabled_no_wake: assert property (!en_reg[2]
		|-> !hit[2])
		else $error("disabled input raised a wake");
	a_release_on_hit: assert property (hit != 4'h0
		|=> standby_release)
		else $error("release request missing after a wake");
	a_release_quiet: assert property (hit == 4'h0
		|=> !standby_release)
		else $error("release request without a wake");
	a_pend_on_hit: assert property (hit != 4'h0
		|=> (wake_pending & $past(hit)) == $past(hit))
		else $error("pending bit not set by its wake");
	a_enable_from_write: assert property (wr_acc && paddr == swsc_pkg::mode_a_offset
		|=> en_reg[3] == $past(pwdata[24]) && en_reg[2] == $past(pwdata[16]))
		else $error("enable bits not taken from 24 and 16");
	a_lane3_from_write: assert property (wr_acc && paddr == swsc_pkg::mode_a_offset
		|=> cond_reg[3] == $past(pwdata[30:28]))
		else $error("input 3 condition not taken from its bits");
	a_cond2_from_write: assert property (wr_acc && paddr == swsc_pkg::mode_a_offset
		|=> cond_reg[2] == $past(pwdata[22:20]) && cond_reg[1] == $past(pwdata[14:12]))
		else $error("condition field not taken from its bits");
	a_cond0_from_write: assert property (wr_acc && paddr == swsc_pkg::mode_a_offset
		|=> cond_reg[0] == $past(pwdata[6:4]) && en_reg[0] == $past(pwdata[0]))
		else $error("input 0 fields misplaced");
	a_enable1_from_write: assert property (wr_acc && paddr == swsc_pkg::mode_a_offset
		|=> en_reg[1] == $past(pwdata[8]))
		else $error("input 1 enable not taken from bit 8");
	a_seen_read_only: assert property (wr_acc && paddr == swsc_pkg::mode_a_offset && !hit[0]
		|=> $stable(seen[0]))
		else $error("edge status changed by a register write");
	a_seen_only_either: assert property (cond_reg[3] != swsc_pkg::cond_either && !clr[3]
		|=> $stable(seen[3]))
		else $error("edge status changed outside either-edge mode");
	a_clear_seen: assert property (clr[2] && !hit[2]
		|=> seen[2] == swsc_pkg::seen_none)
		else $error("edge status not cleared with pending");
	a_pend_clear: assert property (clr[2] && !hit[2]
		|=> !wake_pending[2])
		else $error("pending bit not cleared");
	a_rise_code: assert property (en_reg[2] && cond_reg[2] == swsc_pkg::cond_either && !clr[2]
		&& $rose(wake_input[2]) && seen[2] == swsc_pkg::seen_none |=> seen[2] == swsc_pkg::seen_rising)
		else $error("rising edge not reported as 01");
	a_fall_code: assert property (en_reg[2] && cond_reg[2] == swsc_pkg::cond_either && !clr[2]
		&& $fell(wake_input[2]) && seen[2] == swsc_pkg::seen_rising |=> seen[2] == swsc_pkg::seen_both)
		else $error("rise then fall not reported as 11");
	a_high_level_hit: assert property (en_reg[1] && cond_reg[1] == swsc_pkg::cond_high && wake_input[1]
		|=> wake_pending[1] && standby_release)
		else $error("high level did not wake");
	a_low_level_hit: assert property (en_reg[2] && cond_reg[2] == swsc_pkg::cond_low && !wake_input[2]
		|=> wake_pending[2] && standby_release)
		else $error("low level did not wake");
	a_err_unmapped: assert property ((wr_acc || rd_acc)
		|-> pslverr == !mapped)
		else $error("error flag wrong for the address");
	a_apb_one_wait: assert property (psel && penable && !ready_reg
		|=> pready ##1 !pready)
		else $error("apb answer timing wrong");

	// ----------------------------------------------------------------
	// Cover points
	// ----------------------------------------------------------------
	c_either_wake:  cover property (cond_reg[2] == swsc_pkg::cond_either && hit[2]);
	c_level_wake:   cover property (cond_reg[1] == swsc_pkg::cond_high && hit[1]);
	c_both_seen:    cover property (seen[2] == swsc_pkg::seen_both);
	c_clear_pend:   cover property (clr != 4'h0 && pend_reg != 4'h0);
	c_release_once: cover property (standby_release ##1 !standby_release);

endmodule : swsc_top
`default_nettype wire

// File: dv/swsc_pins.sv
// Behavioural model of the wake pins driven by the bench
`timescale 1ns/10ps
`default_nettype none
module swsc_pins (
	input  wire logic       clk,        // System clock
	input  wire logic [3:0] level_req,  // Requested pin levels
	output logic      [3:0] wake_input  // Pin levels, synchronous to clk
);
	// Levels move only after an edge, so the block never sees a change inside a cycle
	always_ff @(posedge clk) begin
		wake_input <= level_req;
	end
endmodule : swsc_pins
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the standby wake-source block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  level_req = 4'h0;
	logic [3:0]  wake_input;
	logic [3:0]  wake_pending;
	logic        standby_release;
	logic [32:0] notes[$];
	logic [32:0] note;
	logic [31:0] word;
	logic [2:0]  code;
	int          mismatches = 0;
	int          checked = 0;
	int          releases = 0;

	always #2.5 clk = ~clk;

	swsc_pins pins (.clk(clk), .level_req(level_req), .wake_input(wake_input));
	swsc_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wake_input(wake_input), .wake_pending(wake_pending), .standby_release(standby_release));

	// ------
	// Tasks
	// ------
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			mismatches++;
			test_done();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// The note goes in before the transfer so the monitor never finds the queue empty
	task automatic rd(input logic [11:0] a, input logic [32:0] exp);
		notes.push_back(exp);
		apb(1'b0, a, 32'h0);
	endtask : rd

	always @(posedge clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			note = notes.pop_front();
			check("apb_read", {pslverr, prdata}, note);
		end
	end

	// Release pulses are counted so a missing or doubled pulse shows up
	always @(posedge clk) begin
		if (standby_release === 1'b1) begin
			releases++;
		end
	end

	// ------
	// Main sequence
	// ------
	initial begin
		void'($urandom(32'h370165c0));
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		rd(12'h000, {1'b0, 32'h20202020});
		rd(12'h008, 33'h0);
		$display("test reset_values done");
		for (int k = 0; k < 2; k++) begin
			word = 32'h0;
			for (int i = 0; i < 4; i++) begin
				code = (k * 4 + i < 5) ? 3'(k * 4 + i) : 3'($urandom % 5);
				word[8 * i +: 8] = {1'b0, code, 4'h0};
			end
			// Status and spare bits written as ones must still read back zero
			apb(1'b1, 12'h000, word | 32'h8e8e8e8e);
			rd(12'h000, {1'b0, word});
			rd(12'h008, 33'h0);
		end
		$display("test field_layout done");
		apb(1'b1, 12'h000, 32'h40404040);
		apb(1'b1, 12'h000, 32'h40414041);
		level_req <= 4'h4;
		repeat (4) @(posedge clk);
		check("pending_pins", {29'h0, wake_pending}, 33'h4);
		rd(12'h000, {1'b0, 32'h40454041});
		level_req <= 4'h0;
		repeat (4) @(posedge clk);
		rd(12'h000, {1'b0, 32'h404d4041});
		apb(1'b1, 12'h004, 32'h4);
		rd(12'h000, {1'b0, 32'h40414041});
		rd(12'h008, 33'h0);
		$display("test either_edge done");
		apb(1'b1, 12'h000, 32'h20414041);
		apb(1'b1, 12'h000, 32'h21414041);
		level_req <= 4'h8;
		repeat (4) @(posedge clk);
		rd(12'h008, 33'h0);
		level_req <= 4'h0;
		repeat (4) @(posedge clk);
		rd(12'h008, 33'h8);
		rd(12'h000, {1'b0, 32'h21414041});
		rd(12'h010, {1'b1, 32'h0});
		rd(12'h00c, 33'h8);
		check("release_count", 33'(releases), 33'h3);
		$display("test falling_edge done");
		// Level and rising modes: conditions go in with the enables off, the enables follow
		apb(1'b1, 12'h000, 32'h00001030);
		apb(1'b1, 12'h004, 32'hf);
		level_req <= 4'h4;
		apb(1'b1, 12'h000, 32'h00011131);
		rd(12'h008, 33'h0);
		level_req <= 4'h7;
		repeat (4) @(posedge clk);
		rd(12'h008, 33'h3);
		rd(12'h000, {1'b0, 32'h00011131});
		level_req <= 4'h0;
		apb(1'b1, 12'h004, 32'h3);
		rd(12'h008, 33'h4);
		$display("test level_modes done");
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(12'h000, {1'b0, 32'h20202020});
		rd(12'h008, 33'h0);
		rd(12'h00c, 33'h0);
		$display("test mid_reset done");
		test_done();
	end
endmodule : tb
`default_nettype wire
